// ==== sim/nfc_flash_model.sv ====
// Purpose: Behavioural flash that logs host write cycles and answers reads.
// Assumes: Word mode; writes are captured on the falling write strobe.
// Notes: Only identification and one-time region modes are tracked.
`timescale 1ns/1ps
module nfc_flash_model #(
    parameter logic [15:0] MAKER_ID = 16'h00A5, // Arbitrary value.
    parameter logic [15:0] PART1_ID = 16'h1A01, // Arbitrary value.
    parameter logic [15:0] PART2_ID = 16'h1A0E, // Arbitrary value.
    parameter logic [15:0] PART3_ID = 16'h1A0F, // Arbitrary value.
    parameter logic [15:0] INDIC_W = 16'h0042,
    parameter logic [15:0] LOCK_W = 16'h0001
) (
    input wire logic [22:0] addr_i,
    input wire logic [15:0] dq_i,
    input wire logic ce_n_i,
    input wire logic oe_n_i,
    input wire logic we_n_i,
    output logic [15:0] dq_o
);
    logic [38:0] wq[$];
    logic [18:0] h1 = 19'h0_0000;
    logic [18:0] h2 = 19'h0_0000;
    logic [18:0] w;
    logic ident = 1'b0;
    logic otp = 1'b0;
    logic drv;
    logic [15:0] word;
    logic [15:0] last_q = 16'h0000;
    always @(negedge we_n_i) begin
        if (ce_n_i == 1'b0) begin
            wq.push_back({addr_i, dq_i});
            w = {addr_i[10:0], dq_i[7:0]};
            if (h2 == {11'h555, 8'hAA} && h1 == {11'h2AA, 8'h55}) begin
                if (w == {11'h555, 8'h90}) ident = 1'b1;
                if (w == {11'h555, 8'h88}) otp = 1'b1;
            end
            if (w[7:0] == 8'hF0) ident = 1'b0;
            if (w[7:0] == 8'h00 && h1[7:0] == 8'h90) begin
                ident = 1'b0;
                otp = 1'b0;
            end
            h2 = h1;
            h1 = w;
        end
    end
    always @* begin
        if (ident) begin
            case (addr_i[7:0])
                8'h00: word = MAKER_ID;
                8'h01: word = PART1_ID;
                8'h0E: word = PART2_ID;
                8'h0F: word = PART3_ID;
                8'h02: word = {15'h0000, addr_i[16]};
                8'h03: word = INDIC_W;
                8'h07: word = LOCK_W;
                default: word = 16'h0000;
            endcase
        end else if (otp) begin
            word = addr_i[15:0] ^ 16'h0F0F;
        end else begin
            word = addr_i[15:0] ^ 16'hC3C3;
        end
    end
    assign drv = !ce_n_i && !oe_n_i && we_n_i;
    // A released bus shows the inverse of the last word so stale data never matches.
    always @* if (drv) last_q = word;
    assign dq_o = drv ? word : ~last_q;
endmodule : nfc_flash_model

// ==== sim/tb.sv ====
// Purpose: Self-checking bench of nfc_host against a behavioural flash.
// Assumes: Default pin timing parameters of the sequencer.
// Notes: Expected cycles and read words come from the bench's own tables.
`timescale 1ns/1ps
`include "nfc_defs.svh"
module tb
    import nfc_pkg::*;
;
    localparam logic [15:0] MK = 16'h00A5;
    localparam logic [15:0] P1 = 16'h1A01;
    localparam logic [15:0] P2 = 16'h1A0E;
    localparam logic [15:0] P3 = 16'h1A0F;
    localparam logic [15:0] IW = 16'h0042;
    localparam logic [15:0] LW = 16'h0001;
    logic mclk_i = 1'b0;
    logic rst_n_i, clk_en_i, req_valid_i, req_ready_o, rsp_valid_o, rsp_err_o;
    nfc_req_s req_i;
    logic [15:0] rsp_data_o, mdl_dq, flash_dq_i, d;
    nfc_mode_e mode_o;
    nfc_bus_s flash_o;
    int n_errors = 0;
    int total_checks = 0;
    int i;
    integer seed;
    logic [38:0] exq[$];
    logic [15:0] erq[$];
    logic [22:0] a, b, blk;
    always #12.5 mclk_i = ~mclk_i;
    assign flash_dq_i = flash_o.dq_oe_n ? mdl_dq : flash_o.dq;
    nfc_host dut_u (.mclk_i(mclk_i), .rst_n_i(rst_n_i), .clk_en_i(clk_en_i), .req_valid_i(req_valid_i),
        .req_i(req_i), .req_ready_o(req_ready_o), .rsp_valid_o(rsp_valid_o), .rsp_err_o(rsp_err_o),
        .rsp_data_o(rsp_data_o), .mode_o(mode_o), .flash_o(flash_o), .flash_dq_i(flash_dq_i));
    nfc_flash_model #(.MAKER_ID(MK), .PART1_ID(P1), .PART2_ID(P2), .PART3_ID(P3), .INDIC_W(IW), .LOCK_W(LW))
        flash_u (.addr_i(flash_o.addr), .dq_i(flash_dq_i), .ce_n_i(flash_o.ce_n), .oe_n_i(flash_o.oe_n),
        .we_n_i(flash_o.we_n), .dq_o(mdl_dq));
    task automatic conclude;
        $display("checks %0d mismatches %0d", total_checks, n_errors);
        if (n_errors == 0 && total_checks > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask : conclude
    task automatic chk(input string nm, input logic [38:0] e, input logic [38:0] g);
        total_checks++;
        if (g !== e) begin
            $display("BAD %s expected %h seen %h", nm, e, g);
            n_errors++;
        end
    endtask : chk
    task automatic pc(input logic [22:0] ad, input logic [7:0] c);
        exq.push_back({ad, 8'h00, c});
    endtask : pc
    task automatic ul;
        pc(`NFC_ADDR_UNLK1, `NFC_CMD_UNLK1);
        pc(`NFC_ADDR_UNLK2, `NFC_CMD_UNLK2);
    endtask : ul
    task automatic run(input nfc_op_e op, input logic [22:0] ad, input logic [15:0] dt, input logic [8:0] c,
        input logic err, input nfc_mode_e md, input int nr);
        int k;
        int got;
        flash_u.wq.delete();
        @(negedge mclk_i);
        req_i = '{op: op, addr: ad, data: dt, cnt: c};
        chk({op.name(), " ready"}, 39'(1), 39'(req_ready_o));
        req_valid_i = 1'b1;
        @(negedge mclk_i);
        req_valid_i = 1'b0;
        got = 0;
        for (k = 0; k < 300 && got < nr; k++) begin
            if (rsp_valid_o === 1'b1) begin
                chk({op.name(), " err"}, 39'(err), 39'(rsp_err_o));
                if (erq.size() > 0) chk({op.name(), " read"}, 39'(erq.pop_front()), 39'(rsp_data_o));
                got++;
            end
            if (got < nr) @(negedge mclk_i);
        end
        if (got < nr) begin
            $display("BAD %s answer expected %0d seen %0d", op.name(), nr, got);
            n_errors++;
            conclude();
        end
        chk({op.name(), " cycles"}, 39'(exq.size()), 39'(flash_u.wq.size()));
        for (k = 0; k < exq.size() && k < flash_u.wq.size(); k++)
            chk({op.name(), " cycle"}, exq[k], flash_u.wq[k]);
        chk({op.name(), " mode"}, 39'(md), 39'(mode_o));
        exq.delete();
        erq.delete();
    endtask : run
    initial begin
        seed = 32'h0564;
        rst_n_i = 1'b0;
        clk_en_i = 1'b1;
        req_valid_i = 1'b0;
        req_i = '0;
        repeat (2) @(negedge mclk_i);
        rst_n_i = 1'b1;
        for (i = 0; i < 4; i++) begin
            a = 23'($random(seed));
            d = 16'($random(seed));
            ul();
            pc(`NFC_ADDR_UNLK1, `NFC_CMD_PROG);
            exq.push_back({a, d});
            run(NFC_OP_PROGRAM, a, d, 9'h000, 1'b0, NFC_MODE_ARRAY, 1);
        end
        $display("test program finished");
        b = 23'h05_0000;
        ul();
        pc(`NFC_ADDR_UNLK1, `NFC_CMD_IDENT);
        run(NFC_OP_ID_ENTER, b, 16'h0000, 9'h000, 1'b0, NFC_MODE_IDENT, 1);
        erq.push_back(MK);
        run(NFC_OP_ID_MAKER, b, 16'h0000, 9'h000, 1'b0, NFC_MODE_IDENT, 1);
        erq = '{P1, P2, P3};
        run(NFC_OP_ID_PART, b, 16'h0000, 9'h000, 1'b0, NFC_MODE_IDENT, 3);
        erq.push_back(16'h0001);
        run(NFC_OP_ID_PROTECT, b, 16'h0000, 9'h000, 1'b0, NFC_MODE_IDENT, 1);
        erq.push_back(IW);
        run(NFC_OP_ID_INDIC, b, 16'h0000, 9'h000, 1'b0, NFC_MODE_IDENT, 1);
        erq.push_back(LW);
        run(NFC_OP_ID_LOCK, b, 16'h0000, 9'h000, 1'b0, NFC_MODE_IDENT, 1);
        pc(b, `NFC_CMD_RESET);
        run(NFC_OP_RESET, b, 16'h0000, 9'h000, 1'b0, NFC_MODE_ARRAY, 1);
        erq.push_back(b[15:0] ^ 16'hC3C3);
        run(NFC_OP_READ, b, 16'h0000, 9'h000, 1'b0, NFC_MODE_ARRAY, 1);
        $display("test ident finished");
        run(NFC_OP_ID_MAKER, b, 16'h0000, 9'h000, 1'b1, NFC_MODE_ARRAY, 1);
        run(NFC_OP_BUF_START, b, 16'h0000, 9'h000, 1'b1, NFC_MODE_ARRAY, 1);
        b = 23'h12_3456;
        blk = 23'h12_0000;
        ul();
        pc(blk, `NFC_CMD_BUF_LOAD);
        pc(blk, 8'h01);
        run(NFC_OP_BUF_START, b, 16'h0000, 9'h002, 1'b0, NFC_MODE_BUFLD, 1);
        run(NFC_OP_BUF_COMMIT, b, 16'h0000, 9'h000, 1'b1, NFC_MODE_BUFLD, 1);
        for (i = 0; i < 2; i++) begin
            a = blk + 23'(i);
            d = 16'($random(seed));
            exq.push_back({a, d});
            run(NFC_OP_BUF_WORD, a, d, 9'h000, 1'b0, NFC_MODE_BUFLD, 1);
        end
        run(NFC_OP_BUF_WORD, a, d, 9'h000, 1'b1, NFC_MODE_BUFLD, 1);
        pc(blk, `NFC_CMD_BUF_COMMIT);
        run(NFC_OP_BUF_COMMIT, b, 16'h0000, 9'h000, 1'b0, NFC_MODE_ARRAY, 1);
        ul();
        pc(`NFC_ADDR_UNLK1, `NFC_CMD_RESET);
        run(NFC_OP_BUF_ABORT, b, 16'h0000, 9'h000, 1'b0, NFC_MODE_ARRAY, 1);
        $display("test buffer finished");
        ul();
        pc(`NFC_ADDR_UNLK1, `NFC_CMD_BYPASS);
        run(NFC_OP_BYP_ENTER, b, 16'h0000, 9'h000, 1'b0, NFC_MODE_BYPASS, 1);
        a = 23'($random(seed));
        d = 16'($random(seed));
        pc(a, `NFC_CMD_PROG);
        exq.push_back({a, d});
        run(NFC_OP_PROGRAM, a, d, 9'h000, 1'b0, NFC_MODE_BYPASS, 1);
        pc(b, `NFC_CMD_ERASE);
        pc(blk, `NFC_CMD_BLOCK);
        run(NFC_OP_BLOCK_ERASE, b, 16'h0000, 9'h000, 1'b0, NFC_MODE_BYPASS, 1);
        pc(b, `NFC_CMD_ERASE);
        pc(`NFC_ADDR_UNLK1, `NFC_CMD_CHIP);
        run(NFC_OP_CHIP_ERASE, b, 16'h0000, 9'h000, 1'b0, NFC_MODE_BYPASS, 1);
        pc(b, `NFC_CMD_IDENT);
        pc(b, `NFC_CMD_EXIT);
        run(NFC_OP_BYP_EXIT, b, 16'h0000, 9'h000, 1'b0, NFC_MODE_ARRAY, 1);
        $display("test bypass finished");
        for (i = 0; i < 2; i++) begin
            ul();
            pc(`NFC_ADDR_UNLK1, `NFC_CMD_ERASE);
            ul();
            if (i == 0) pc(`NFC_ADDR_UNLK1, `NFC_CMD_CHIP);
            else pc(blk, `NFC_CMD_BLOCK);
            run(i == 0 ? NFC_OP_CHIP_ERASE : NFC_OP_BLOCK_ERASE, b, 16'h0000, 9'h000, 1'b0, NFC_MODE_ARRAY, 1);
        end
        pc(b, `NFC_CMD_SUSPEND);
        run(NFC_OP_SUSPEND, b, 16'h0000, 9'h000, 1'b0, NFC_MODE_ARRAY, 1);
        erq.push_back(16'h7777 ^ 16'hC3C3);
        run(NFC_OP_READ, 23'h34_7777, 16'h0000, 9'h000, 1'b0, NFC_MODE_ARRAY, 1);
        pc(b, `NFC_CMD_RESUME);
        run(NFC_OP_RESUME, b, 16'h0000, 9'h000, 1'b0, NFC_MODE_ARRAY, 1);
        $display("test erase finished");
        ul();
        pc(`NFC_ADDR_UNLK1, `NFC_CMD_OTP);
        run(NFC_OP_OTP_ENTER, b, 16'h0000, 9'h000, 1'b0, NFC_MODE_OTP, 1);
        erq.push_back(16'h00FF ^ 16'h0F0F);
        run(NFC_OP_READ, `NFC_OTP_LAST, 16'h0000, 9'h000, 1'b0, NFC_MODE_OTP, 1);
        run(NFC_OP_READ, 23'h00_0100, 16'h0000, 9'h000, 1'b1, NFC_MODE_OTP, 1);
        ul();
        pc(`NFC_ADDR_UNLK1, `NFC_CMD_PROG);
        exq.push_back({23'h00_0080, d});
        run(NFC_OP_PROGRAM, 23'h00_0080, d, 9'h000, 1'b0, NFC_MODE_OTP, 1);
        ul();
        pc(`NFC_ADDR_UNLK1, `NFC_CMD_IDENT);
        pc(23'h00_0010, `NFC_CMD_EXIT);
        run(NFC_OP_OTP_EXIT, 23'h00_0010, 16'h0000, 9'h000, 1'b0, NFC_MODE_ARRAY, 1);
        erq.push_back(16'h00FF ^ 16'hC3C3);
        run(NFC_OP_READ, `NFC_OTP_LAST, 16'h0000, 9'h000, 1'b0, NFC_MODE_ARRAY, 1);
        $display("test otp finished");
        conclude();
    end
endmodule : tb

// ==== src/nfc_defs.svh ====
// Purpose: Constants of the NOR flash command sequencer.
// Assumes: Word (x16) mode, word addresses.
// Notes: Pin timings are plain defaults; set them for the part in use.
`ifndef NFC_DEFS_SVH
`define NFC_DEFS_SVH
`define NFC_AW 23
`define NFC_DW 16
`define NFC_CW 9
`define NFC_ADDR_UNLK1 23'h00_0555
`define NFC_ADDR_UNLK2 23'h00_02AA
`define NFC_OTP_LAST 23'h00_00FF
`define NFC_BLK_LSB 16
`define NFC_BLK_MSB 22
`define NFC_CMD_UNLK1 8'hAA
`define NFC_CMD_UNLK2 8'h55
`define NFC_CMD_RESET 8'hF0
`define NFC_CMD_IDENT 8'h90
`define NFC_CMD_PROG 8'hA0
`define NFC_CMD_BUF_LOAD 8'h25
`define NFC_CMD_BUF_COMMIT 8'h29
`define NFC_CMD_BYPASS 8'h20
`define NFC_CMD_ERASE 8'h80
`define NFC_CMD_CHIP 8'h10
`define NFC_CMD_BLOCK 8'h30
`define NFC_CMD_SUSPEND 8'hB0
`define NFC_CMD_RESUME 8'h30
`define NFC_CMD_OTP 8'h88
`define NFC_CMD_EXIT 8'h00
`define NFC_ID_MAKER 8'h00
`define NFC_ID_PART1 8'h01
`define NFC_ID_PART2 8'h0E
`define NFC_ID_PART3 8'h0F
`define NFC_ID_PROT 8'h02
`define NFC_ID_INDIC 8'h03
`define NFC_ID_LOCK 8'h07
`define NFC_CLK_NS 25
`define NFC_T_WE_NS 35
`define NFC_T_REC_NS 20
`define NFC_T_ACC_NS 65
`define NFC_SYNC_STAGES 2
`define NFC_WE_CYC ((`NFC_T_WE_NS + `NFC_CLK_NS - 1) / `NFC_CLK_NS)
`define NFC_REC_CYC ((`NFC_T_REC_NS + `NFC_CLK_NS - 1) / `NFC_CLK_NS)
`define NFC_RD_CYC (((`NFC_T_ACC_NS + `NFC_CLK_NS - 1) / `NFC_CLK_NS) + `NFC_SYNC_STAGES)
`endif

// ==== src/nfc_host.sv ====
// Purpose: Host-side sequencer that turns user operations into NOR flash bus cycles.
// Assumes: Word mode; the flash data bus is resolved outside from flash_o.dq_oe_n.
// Notes: Completion of program and erase is not polled here.
// Behaviour
// - Each mode entered by its own cycle series.
// - Reset command F0 ends identification mode.
// - Identification entry AA, 55, 90; maker at 00.
// - Part code read at offsets 01, 0E, 0F.
// - Program: prefix, A0, then data word.
// - Buffer: prefix, 25, count, data words.
// - Write 29 to block to commit.
// - Abort recovery: AA, 55, then F0.
// - Bypass mode uses two-cycle commands.
// - Erase is six writes, chip or block.
// - Suspend B0, resume 30, any address.
// - Prefix then 88 enters OTP region.
// - Prefix, 90, 00 leaves OTP region.
// - OTP mode keeps addresses inside region.
`timescale 1ns/1ps
`include "nfc_defs.svh"
module nfc_host
    import nfc_pkg::*;
#(
    parameter int WE_CYC = `NFC_WE_CYC,
    parameter int REC_CYC = `NFC_REC_CYC,
    parameter int RD_CYC = `NFC_RD_CYC
) (
    input wire logic mclk_i,
    input wire logic rst_n_i,
    input wire logic clk_en_i,
    input wire logic req_valid_i,
    input wire nfc_req_s req_i,
    output logic req_ready_o,
    output logic rsp_valid_o,
    output logic rsp_err_o,
    output logic [`NFC_DW-1:0] rsp_data_o,
    output nfc_mode_e mode_o,
    output nfc_bus_s flash_o,
    input wire logic [`NFC_DW-1:0] flash_dq_i
);
    localparam logic [3:0] WE_LD = 4'(WE_CYC - 1);
    localparam logic [3:0] REC_LD = 4'(REC_CYC - 1);
    localparam logic [3:0] RD_LD = 4'(RD_CYC - 1);
    localparam nfc_bus_s BUS_IDLE = '{addr: '0, dq: '0, ce_n: 1'b1, oe_n: 1'b1, we_n: 1'b1, dq_oe_n: 1'b1};

    nfc_state_e st_q;
    nfc_mode_e mode_q;
    nfc_req_s cur_q;
    nfc_req_s req_sel;
    nfc_step_s stp_q;
    nfc_step_s nxt;
    nfc_bus_s bus_q;
    logic [3:0] step_q;
    logic [3:0] tmr_q;
    logic [3:0] idx;
    logic byp_q;
    logic byp_sel;
    logic [`NFC_CW-1:0] rem_q;
    logic [`NFC_DW-1:0] dq_s1_q;
    logic [`NFC_DW-1:0] dq_s2_q;
    logic legal;
    logic acc;
    logic pulse_end;
    logic rec_end;
    logic rsp_valid_q;
    logic rsp_err_q;
    logic [`NFC_DW-1:0] rsp_data_q;

    function automatic nfc_step_s wr_f(input logic [`NFC_AW-1:0] a, input logic [7:0] c, input logic l);
        wr_f = '{addr: a, data: {8'h00, c}, rd: 1'b0, last: l, pw: 1'b0};
    endfunction : wr_f

    function automatic nfc_step_s rd_f(input logic [`NFC_AW-1:0] a, input logic l);
        rd_f = '{addr: a, data: '0, rd: 1'b1, last: l, pw: 1'b0};
    endfunction : rd_f

    function automatic nfc_step_s step_f(input logic [3:0] n, input nfc_req_s r, input logic byp);
        logic [`NFC_AW-1:0] blk;
        logic [`NFC_DW-1:0] wn;
        nfc_step_s s;
        blk = {r.addr[`NFC_BLK_MSB:`NFC_BLK_LSB], 16'h0000};
        wn = 16'(r.cnt) - 16'h0001;
        s = wr_f(`NFC_ADDR_UNLK1, `NFC_CMD_UNLK1, 1'b0);
        if (n == 4'h1 || n == 4'h4) begin
            s = wr_f(`NFC_ADDR_UNLK2, `NFC_CMD_UNLK2, 1'b0);
        end
        case (r.op)
            NFC_OP_READ: s = rd_f(r.addr, 1'b1);
            NFC_OP_RESET: s = wr_f(r.addr, `NFC_CMD_RESET, 1'b1);
            NFC_OP_ID_ENTER: if (n == 4'h2) s = wr_f(`NFC_ADDR_UNLK1, `NFC_CMD_IDENT, 1'b1);
            NFC_OP_ID_MAKER: s = rd_f({blk[22:8], `NFC_ID_MAKER}, 1'b1);
            NFC_OP_ID_PART: begin
                s = rd_f({blk[22:8], `NFC_ID_PART1}, 1'b0);
                if (n == 4'h1) s = rd_f({blk[22:8], `NFC_ID_PART2}, 1'b0);
                if (n == 4'h2) s = rd_f({blk[22:8], `NFC_ID_PART3}, 1'b1);
            end
            NFC_OP_ID_PROTECT: s = rd_f({blk[22:8], `NFC_ID_PROT}, 1'b1);
            NFC_OP_ID_INDIC: s = rd_f({blk[22:8], `NFC_ID_INDIC}, 1'b1);
            NFC_OP_ID_LOCK: s = rd_f({blk[22:8], `NFC_ID_LOCK}, 1'b1);
            NFC_OP_PROGRAM: begin
                if (byp && n == 4'h0) s = wr_f(r.addr, `NFC_CMD_PROG, 1'b0);
                if (!byp && n == 4'h2) s = wr_f(`NFC_ADDR_UNLK1, `NFC_CMD_PROG, 1'b0);
                if ((byp && n == 4'h1) || n == 4'h3) begin
                    s = '{addr: r.addr, data: r.data, rd: 1'b0, last: 1'b1, pw: 1'b1};
                end
            end
            NFC_OP_BUF_START: begin
                if (n == 4'h2) s = wr_f(blk, `NFC_CMD_BUF_LOAD, 1'b0);
                if (n == 4'h3) s = '{addr: blk, data: wn, rd: 1'b0, last: 1'b1, pw: 1'b1};
            end
            NFC_OP_BUF_WORD: s = '{addr: r.addr, data: r.data, rd: 1'b0, last: 1'b1, pw: 1'b1};
            NFC_OP_BUF_COMMIT: s = wr_f(blk, `NFC_CMD_BUF_COMMIT, 1'b1);
            NFC_OP_BUF_ABORT: if (n == 4'h2) s = wr_f(`NFC_ADDR_UNLK1, `NFC_CMD_RESET, 1'b1);
            NFC_OP_BYP_ENTER: if (n == 4'h2) s = wr_f(`NFC_ADDR_UNLK1, `NFC_CMD_BYPASS, 1'b1);
            NFC_OP_BYP_EXIT: begin
                s = wr_f(r.addr, `NFC_CMD_IDENT, 1'b0);
                if (n == 4'h1) s = wr_f(r.addr, `NFC_CMD_EXIT, 1'b1);
            end
            NFC_OP_CHIP_ERASE, NFC_OP_BLOCK_ERASE: begin
                if (byp && n == 4'h0) s = wr_f(r.addr, `NFC_CMD_ERASE, 1'b0);
                if (!byp && n == 4'h2) s = wr_f(`NFC_ADDR_UNLK1, `NFC_CMD_ERASE, 1'b0);
                if ((byp && n == 4'h1) || n == 4'h5) begin
                    if (r.op == NFC_OP_CHIP_ERASE) s = wr_f(`NFC_ADDR_UNLK1, `NFC_CMD_CHIP, 1'b1);
                    else s = wr_f(blk, `NFC_CMD_BLOCK, 1'b1);
                end
            end
            NFC_OP_SUSPEND: s = wr_f(r.addr, `NFC_CMD_SUSPEND, 1'b1);
            NFC_OP_RESUME: s = wr_f(r.addr, `NFC_CMD_RESUME, 1'b1);
            NFC_OP_OTP_ENTER: if (n == 4'h2) s = wr_f(`NFC_ADDR_UNLK1, `NFC_CMD_OTP, 1'b1);
            NFC_OP_OTP_EXIT: begin
                if (n == 4'h2) s = wr_f(`NFC_ADDR_UNLK1, `NFC_CMD_IDENT, 1'b0);
                if (n == 4'h3) s = wr_f(r.addr, `NFC_CMD_EXIT, 1'b1);
            end
            default: s = rd_f(r.addr, 1'b1);
        endcase
        return s;
    endfunction : step_f

    // The host mirrors the device mode so that it never sends a sequence the device would throw away.
    always_comb begin
        legal = 1'b0;
        case (req_i.op)
            NFC_OP_READ: legal = mode_q != NFC_MODE_BUFLD;
            NFC_OP_RESET: legal = mode_q == NFC_MODE_ARRAY || mode_q == NFC_MODE_IDENT;
            NFC_OP_ID_ENTER, NFC_OP_BUF_START, NFC_OP_BYP_ENTER, NFC_OP_OTP_ENTER,
            NFC_OP_SUSPEND, NFC_OP_RESUME: legal = mode_q == NFC_MODE_ARRAY;
            NFC_OP_ID_MAKER, NFC_OP_ID_PART, NFC_OP_ID_PROTECT, NFC_OP_ID_INDIC,
            NFC_OP_ID_LOCK: legal = mode_q == NFC_MODE_IDENT;
            NFC_OP_PROGRAM: legal = mode_q == NFC_MODE_ARRAY || mode_q == NFC_MODE_BYPASS || mode_q == NFC_MODE_OTP;
            NFC_OP_BUF_WORD: legal = mode_q == NFC_MODE_BUFLD && rem_q != '0;
            NFC_OP_BUF_COMMIT: legal = mode_q == NFC_MODE_BUFLD && rem_q == '0;
            NFC_OP_BUF_ABORT: legal = mode_q == NFC_MODE_BUFLD || mode_q == NFC_MODE_ARRAY;
            NFC_OP_BYP_EXIT: legal = mode_q == NFC_MODE_BYPASS;
            NFC_OP_CHIP_ERASE, NFC_OP_BLOCK_ERASE: legal = mode_q == NFC_MODE_ARRAY || mode_q == NFC_MODE_BYPASS;
            NFC_OP_OTP_EXIT: legal = mode_q == NFC_MODE_OTP;
            default: legal = 1'b0;
        endcase
        if (req_i.op == NFC_OP_BUF_START && req_i.cnt == '0) legal = 1'b0;
        if (mode_q == NFC_MODE_OTP && req_i.addr > `NFC_OTP_LAST) legal = 1'b0;
    end

    assign req_ready_o = st_q == NFC_ST_IDLE;
    assign acc = clk_en_i && req_valid_i && req_ready_o;
    assign req_sel = (st_q == NFC_ST_IDLE) ? req_i : cur_q;
    assign byp_sel = (st_q == NFC_ST_IDLE) ? (mode_q == NFC_MODE_BYPASS) : byp_q;
    assign idx = (st_q == NFC_ST_IDLE) ? 4'h0 : step_q + 4'h1;
    assign nxt = step_f(idx, req_sel, byp_sel);
    assign pulse_end = st_q == NFC_ST_PULSE && tmr_q == 4'h0;
    assign rec_end = st_q == NFC_ST_REC && tmr_q == 4'h0;

    always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            dq_s1_q <= '0;
            dq_s2_q <= '0;
        end else if (clk_en_i) begin
            dq_s1_q <= flash_dq_i;
            dq_s2_q <= dq_s1_q;
        end
    end

    // Address and data settle one cycle before the strobe, and the strobe drops one cycle after chip enable.
    always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            st_q <= NFC_ST_IDLE;
            step_q <= 4'h0;
            tmr_q <= 4'h0;
            cur_q <= '0;
            stp_q <= '0;
            byp_q <= 1'b0;
            bus_q <= BUS_IDLE;
        end else if (clk_en_i) begin
            case (st_q)
                NFC_ST_IDLE: begin
                    if (req_valid_i && legal) begin
                        cur_q <= req_i;
                        byp_q <= byp_sel;
                        step_q <= 4'h0;
                        stp_q <= nxt;
                        bus_q.addr <= nxt.addr;
                        bus_q.dq <= nxt.data;
                        bus_q.ce_n <= 1'b0;
                        bus_q.dq_oe_n <= nxt.rd;
                        st_q <= NFC_ST_ADDR;
                    end
                end
                NFC_ST_ADDR: begin
                    bus_q.we_n <= stp_q.rd;
                    bus_q.oe_n <= !stp_q.rd;
                    tmr_q <= stp_q.rd ? RD_LD : WE_LD;
                    st_q <= NFC_ST_PULSE;
                end
                NFC_ST_PULSE: begin
                    if (tmr_q == 4'h0) begin
                        bus_q.we_n <= 1'b1;
                        bus_q.oe_n <= 1'b1;
                        bus_q.ce_n <= 1'b1;
                        tmr_q <= REC_LD;
                        st_q <= NFC_ST_REC;
                    end else begin
                        tmr_q <= tmr_q - 4'h1;
                    end
                end
                NFC_ST_REC: begin
                    if (tmr_q != 4'h0) begin
                        tmr_q <= tmr_q - 4'h1;
                    end else if (stp_q.last) begin
                        bus_q.dq_oe_n <= 1'b1;
                        st_q <= NFC_ST_IDLE;
                    end else begin
                        step_q <= idx;
                        stp_q <= nxt;
                        bus_q.addr <= nxt.addr;
                        bus_q.dq <= nxt.data;
                        bus_q.ce_n <= 1'b0;
                        bus_q.dq_oe_n <= nxt.rd;
                        st_q <= NFC_ST_ADDR;
                    end
                end
                default: st_q <= NFC_ST_IDLE;
            endcase
        end
    end

    always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            mode_q <= NFC_MODE_ARRAY;
            rem_q <= '0;
        end else if (acc && legal) begin
            case (req_i.op)
                NFC_OP_RESET, NFC_OP_BYP_EXIT, NFC_OP_BUF_COMMIT, NFC_OP_BUF_ABORT: mode_q <= NFC_MODE_ARRAY;
                NFC_OP_OTP_EXIT: mode_q <= NFC_MODE_ARRAY;
                NFC_OP_ID_ENTER: mode_q <= NFC_MODE_IDENT;
                NFC_OP_BYP_ENTER: mode_q <= NFC_MODE_BYPASS;
                NFC_OP_OTP_ENTER: mode_q <= NFC_MODE_OTP;
                NFC_OP_BUF_START: begin
                    mode_q <= NFC_MODE_BUFLD;
                    rem_q <= req_i.cnt;
                end
                NFC_OP_BUF_WORD: rem_q <= rem_q - 1'b1;
                default: mode_q <= mode_q;
            endcase
        end
    end

    always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            rsp_valid_q <= 1'b0;
            rsp_err_q <= 1'b0;
            rsp_data_q <= '0;
        end else if (clk_en_i) begin
            rsp_valid_q <= 1'b0;
            if (st_q == NFC_ST_IDLE && req_valid_i && !legal) begin
                rsp_valid_q <= 1'b1;
                rsp_err_q <= 1'b1;
            end else if (pulse_end && stp_q.rd) begin
                rsp_valid_q <= 1'b1;
                rsp_err_q <= 1'b0;
                rsp_data_q <= dq_s2_q;
            end else if (rec_end && stp_q.last && !stp_q.rd) begin
                rsp_valid_q <= 1'b1;
                rsp_err_q <= 1'b0;
            end
        end
    end

    assign rsp_valid_o = rsp_valid_q;
    assign rsp_err_o = rsp_err_q;
    assign rsp_data_o = rsp_data_q;
    assign mode_o = mode_q;
    assign flash_o = bus_q;

    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (!rst_n_i);

    chk_strobe_excl: assert property (!(!bus_q.we_n && !bus_q.oe_n)) else $error("we and oe low together");
    chk_we_width: assert property ($fell(bus_q.we_n) && clk_en_i |=> bus_q.we_n == 1'b0 ##1 bus_q.we_n) else $error("we pulse width wrong");
    chk_cmd_upper: assert property (!bus_q.we_n && !stp_q.pw |-> bus_q.dq[15:8] == 8'h00) else $error("upper byte set in command");
    chk_addr_stable: assert property (!bus_q.we_n && !$past(bus_q.we_n) |-> $stable(bus_q.addr)) else $error("address moved under we");
    chk_otp_range: assert property (acc && mode_q == NFC_MODE_OTP && req_i.addr > `NFC_OTP_LAST |=> rsp_valid_o && rsp_err_o) else $error("otp address not refused");
    chk_reset_mode: assert property (acc && legal && req_i.op == NFC_OP_RESET |=> mode_q == NFC_MODE_ARRAY) else $error("reset left mode");
    chk_id_mode: assert property (acc && legal && req_i.op == NFC_OP_ID_ENTER |=> mode_q == NFC_MODE_IDENT) else $error("no ident mode");
    chk_otp_exit: assert property (acc && legal && req_i.op == NFC_OP_OTP_EXIT |=> mode_q == NFC_MODE_ARRAY) else $error("otp exit failed");
    chk_rem_load: assert property (acc && legal && req_i.op == NFC_OP_BUF_START |=> rem_q == $past(req_i.cnt)) else $error("count not loaded");
    chk_commit_early: assert property (acc && req_i.op == NFC_OP_BUF_COMMIT && rem_q != '0 |=> rsp_err_o) else $error("early commit taken");
    chk_read_rsp: assert property ($rose(bus_q.oe_n) |-> rsp_valid_o && !rsp_err_o) else $error("read without answer");
    chk_seq_bound: assert property (acc && legal |=> ##[1:80] req_ready_o) else $error("sequence too long");

    cov_id_part: cover property (acc && legal && req_i.op == NFC_OP_ID_PART);
    cov_buf_commit: cover property (acc && legal && req_i.op == NFC_OP_BUF_COMMIT);
    cov_byp_prog: cover property (acc && legal && req_i.op == NFC_OP_PROGRAM && mode_q == NFC_MODE_BYPASS);
    cov_otp_exit: cover property (acc && legal && req_i.op == NFC_OP_OTP_EXIT);
endmodule : nfc_host

// ==== src/nfc_pkg.sv ====
// Purpose: Types of the NOR flash command sequencer.
// Assumes: Constants come from nfc_defs.svh.
// Notes: None.
`include "nfc_defs.svh"
package nfc_pkg;
    typedef enum logic [4:0] {
        NFC_OP_READ, NFC_OP_RESET, NFC_OP_ID_ENTER, NFC_OP_ID_MAKER, NFC_OP_ID_PART,
        NFC_OP_ID_PROTECT, NFC_OP_ID_INDIC, NFC_OP_ID_LOCK, NFC_OP_PROGRAM, NFC_OP_BUF_START,
        NFC_OP_BUF_WORD, NFC_OP_BUF_COMMIT, NFC_OP_BUF_ABORT, NFC_OP_BYP_ENTER, NFC_OP_BYP_EXIT,
        NFC_OP_CHIP_ERASE, NFC_OP_BLOCK_ERASE, NFC_OP_SUSPEND, NFC_OP_RESUME, NFC_OP_OTP_ENTER,
        NFC_OP_OTP_EXIT
    } nfc_op_e;
    typedef enum logic [4:0] {
        NFC_MODE_ARRAY = 5'b00001,
        NFC_MODE_IDENT = 5'b00010,
        NFC_MODE_BYPASS = 5'b00100,
        NFC_MODE_OTP = 5'b01000,
        NFC_MODE_BUFLD = 5'b10000
    } nfc_mode_e;
    typedef enum logic [3:0] {
        NFC_ST_IDLE = 4'b0001,
        NFC_ST_ADDR = 4'b0010,
        NFC_ST_PULSE = 4'b0100,
        NFC_ST_REC = 4'b1000
    } nfc_state_e;
    typedef struct packed {
        nfc_op_e op;
        logic [`NFC_AW-1:0] addr;
        logic [`NFC_DW-1:0] data;
        logic [`NFC_CW-1:0] cnt;
    } nfc_req_s;
    typedef struct packed {
        logic [`NFC_AW-1:0] addr;
        logic [`NFC_DW-1:0] dq;
        logic ce_n;
        logic oe_n;
        logic we_n;
        logic dq_oe_n;
    } nfc_bus_s;
    typedef struct packed {
        logic [`NFC_AW-1:0] addr;
        logic [`NFC_DW-1:0] data;
        logic rd;
        logic last;
        logic pw;
    } nfc_step_s;
endpackage : nfc_pkg
